/* File: inc/fdr_pkg.sv */
package fdr_pkg;
    localparam int COUNT_W = 32;
    localparam int READY_W = 16;
    localparam int DATA_W = 16;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0;
    localparam logic [1:0] BYTES_WORD = 2'h2;
    localparam logic [1:0] BYTES_SINGLE = 2'h1;
    localparam logic [READY_W-1:0] THRESHOLD_SEL0 = 16'h0002;
    localparam logic [READY_W-1:0] THRESHOLD_SEL1 = 16'h0004;
    localparam logic [READY_W-1:0] THRESHOLD_SEL2 = 16'h0008;
    localparam logic [READY_W-1:0] THRESHOLD_SEL3 = 16'h0010;
    // synchronised pin bundle {ack, cs_n, rd_n, wr_n[1:0], data}: strobes idle high
    localparam int PIN_SYNC_W = 21;
    localparam logic [PIN_SYNC_W-1:0] PIN_SYNC_RESET = 21'h0f0000;

    function automatic logic [READY_W-1:0] thresholdBytes(input logic [1:0] sel);
        unique case (sel)
            2'h0: thresholdBytes = THRESHOLD_SEL0;
            2'h1: thresholdBytes = THRESHOLD_SEL1;
            2'h2: thresholdBytes = THRESHOLD_SEL2;
            2'h3: thresholdBytes = THRESHOLD_SEL3;
        endcase
    endfunction
endpackage

/* File: src/fdr_sync2.sv */
`timescale 1ns/1ps
module fdr_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } fdr_sync_state_t;

    fdr_sync_state_t state_reg;
    fdr_sync_state_t state_next;

    // the first stage feeds only the second, so metastability never reaches logic
    always_comb begin
        state_next.stage1 = din;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= {RESET_VAL, RESET_VAL};
        end else begin
            state_reg <= state_next;
        end
    end

    assign dout = state_reg.stage2;
endmodule // fdr_sync2

/* File: src/fdr_dma_request.sv */
`timescale 1ns/1ps
module fdr_dma_request (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // configuration
    input wire logic dirIn,
    input wire logic freeRun,
    input wire logic thrEnable,
    input wire logic [1:0] burstThreshold,
    input wire logic bus16,
    input wire logic reqActiveHigh,
    input wire logic ackActiveHigh,
    // control and status
    input wire logic startPulse,
    input wire logic stopPulse,
    input wire logic [fdr_pkg::COUNT_W-1:0] transferCountIn,
    input wire logic completeClear,
    output logic running,
    output logic completeFlag,
    output logic [fdr_pkg::COUNT_W-1:0] transferCount,
    output logic [fdr_pkg::READY_W-1:0] guaranteedBytes,
    output logic transferDone,
    output logic [1:0] bytesMoved,
    // FIFO status
    input wire logic [fdr_pkg::READY_W-1:0] fifoFree,
    input wire logic [fdr_pkg::READY_W-1:0] fifoData,
    input wire logic fifoReadable,
    // DMA pins
    output logic dmaRequestOut,
    input wire logic dmaAcknowledgeIn,
    // CPU bus pins
    input wire logic chipSelectN,
    input wire logic readStrobeN,
    input wire logic [1:0] byteWriteStrobesN,
    input wire logic [fdr_pkg::DATA_W-1:0] busDataIn,
    output logic [fdr_pkg::DATA_W-1:0] busDataOut,
    output logic busDataOe,
    // register file side
    input wire logic ramWindowSelect,
    input wire logic [fdr_pkg::DATA_W-1:0] regReadData,
    input wire logic [fdr_pkg::DATA_W-1:0] ramReadData,
    output logic [1:0] regWriteEnable,
    output logic [fdr_pkg::DATA_W-1:0] regWriteData
);
    typedef struct packed {
        logic running;
        logic [fdr_pkg::COUNT_W-1:0] count;
        logic request;
        logic [fdr_pkg::READY_W-1:0] guarantee;
        logic complete;
        logic accessPrev;
        logic [1:0] lastBytes;
        logic transferDone;
        logic [1:0] writeLanesPrev;
        logic [fdr_pkg::DATA_W-1:0] writeHold;
        logic [1:0] regWriteEnable;
        logic [fdr_pkg::DATA_W-1:0] regWriteData;
        logic [fdr_pkg::DATA_W-1:0] busDataOut;
        logic readLive;
    } fdr_state_t;

    fdr_state_t state_reg;
    fdr_state_t state_next;
    logic rstN;
    logic [fdr_pkg::PIN_SYNC_W-1:0] pinSync;
    logic ackSync;
    logic csSyncN;
    logic rdSyncN;
    logic [1:0] wrSyncN;
    logic [fdr_pkg::DATA_W-1:0] dataSync;
    logic ackActive;
    logic csActive;
    logic rdActive;
    logic [1:0] writeLanes;
    logic dmaAccess;
    logic accessEnd;
    logic [1:0] accessBytes;
    logic finalAccess;
    logic countExpired;
    logic reqLive;
    logic [fdr_pkg::READY_W-1:0] readyBytes;
    logic [fdr_pkg::READY_W-1:0] thrBytes;

    // reset asserts at once and releases two edges later
    fdr_sync2 #(.W(1), .RESET_VAL(1'b0)) resetSync (
        .clk(sys_clk),
        .rstN(reset_n),
        .din(1'b1),
        .dout(rstN)
    );

    fdr_sync2 #(.W(fdr_pkg::PIN_SYNC_W), .RESET_VAL(fdr_pkg::PIN_SYNC_RESET)) pinSyncer (
        .clk(sys_clk),
        .rstN(rstN),
        .din({dmaAcknowledgeIn, chipSelectN, readStrobeN, byteWriteStrobesN, busDataIn}),
        .dout(pinSync)
    );

    assign {ackSync, csSyncN, rdSyncN, wrSyncN, dataSync} = pinSync;
    assign ackActive = ackActiveHigh ? ackSync : ~ackSync;
    assign csActive = ~csSyncN;
    assign rdActive = ~rdSyncN;
    assign writeLanes = csActive ? ~wrSyncN : 2'h0;
    assign dmaAccess = ackActive & (rdActive | (|(~wrSyncN)));
    assign accessEnd = state_reg.accessPrev & ~dmaAccess;
    // a lone byte on the wide bus only for the last count
    assign accessBytes = (bus16 && (freeRun || state_reg.count != 32'h1)) ?
        fdr_pkg::BYTES_WORD : fdr_pkg::BYTES_SINGLE;
    assign finalAccess = dmaAccess & state_reg.running & ~freeRun &
        (state_reg.count <= {30'h0, accessBytes});
    assign countExpired = accessEnd & state_reg.running & ~freeRun &
        (state_reg.count <= {30'h0, state_reg.lastBytes});
    assign readyBytes = dirIn ? fifoFree : (fifoReadable ? fifoData : 16'h0);
    assign thrBytes = fdr_pkg::thresholdBytes(burstThreshold);

    always_comb begin
        logic [fdr_pkg::COUNT_W-1:0] ready32;
        logic [fdr_pkg::COUNT_W-1:0] thr32;
        logic [fdr_pkg::COUNT_W-1:0] amount;
        logic want;
        ready32 = {16'h0, readyBytes};
        thr32 = {16'h0, thrBytes};
        amount = 32'h0;
        want = 1'b0;
        state_next = state_reg;

        if (thrEnable) begin
            if (freeRun || state_reg.count >= thr32) begin
                want = ready32 >= thr32;
                amount = thr32;
            end else begin
                want = ready32 >= state_reg.count;
                amount = state_reg.count;
            end
        end else if (!freeRun && ready32 >= state_reg.count) begin
            want = 1'b1;
            amount = state_reg.count;
        end else if (bus16) begin
            want = ready32 >= 32'h2;
            amount = ready32 & ~32'h1;
        end else begin
            want = ready32 >= 32'h1;
            amount = ready32;
        end
        if (!freeRun && state_reg.count == fdr_pkg::COUNT_RESET) begin
            want = 1'b0;
        end

        // re-evaluated every cycle, so each access sees fresh FIFO levels
        state_next.request = state_reg.running & want & ~finalAccess & ~countExpired &
            ~stopPulse;
        state_next.guarantee = want ? amount[fdr_pkg::READY_W-1:0] : 16'h0;

        state_next.accessPrev = dmaAccess;
        if (dmaAccess) begin
            state_next.lastBytes = accessBytes;
        end
        state_next.transferDone = accessEnd & state_reg.running;
        if (accessEnd && state_reg.running && !freeRun) begin
            state_next.count = countExpired ? fdr_pkg::COUNT_RESET :
                state_reg.count - {30'h0, state_reg.lastBytes};
        end

        if (completeClear) begin
            state_next.complete = 1'b0;
        end
        // a stop in the clearing cycle still leaves the flag set
        if (state_reg.running && (stopPulse || countExpired)) begin
            state_next.running = 1'b0;
            state_next.complete = 1'b1;
        end else if (startPulse && !state_reg.running && !stopPulse) begin
            state_next.running = 1'b1;
            state_next.count = transferCountIn;
        end

        // strobe edges are only seen after synchronising, so data is held
        // while the strobe is low and committed on its release
        state_next.writeLanesPrev = writeLanes;
        state_next.regWriteEnable = 2'h0;
        if (|writeLanes) begin
            state_next.writeHold = dataSync;
        end
        if ((|state_reg.writeLanesPrev) && !(|writeLanes)) begin
            state_next.regWriteEnable = state_reg.writeLanesPrev;
            state_next.regWriteData = state_reg.writeHold;
        end

        if (csActive && rdActive) begin
            state_next.busDataOut = ramWindowSelect ? ramReadData : regReadData;
        end
        state_next.readLive = csActive & rdActive;
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reqLive = state_reg.request & ~finalAccess;
    assign dmaRequestOut = reqActiveHigh ? reqLive : ~reqLive;
    // enable waits for the first load, so the previous read's data never shows
    assign busDataOe = csActive & rdActive & state_reg.readLive;
    assign busDataOut = state_reg.busDataOut;
    assign running = state_reg.running;
    assign completeFlag = state_reg.complete;
    assign transferCount = state_reg.count;
    assign guaranteedBytes = state_reg.guarantee;
    assign transferDone = state_reg.transferDone;
    assign bytesMoved = state_reg.lastBytes;
    assign regWriteEnable = state_reg.regWriteEnable;
    assign regWriteData = state_reg.regWriteData;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstN);

    a_inbound_space: assert property (
        state_reg.request && $past(dirIn) |-> $past(fifoFree) != 16'h0)
        else $error("inbound request without free space");
    a_outbound_data: assert property (
        state_reg.request && !$past(dirIn) |-> $past(fifoReadable) && $past(fifoData) != 16'h0)
        else $error("outbound request without readable data");
    a_count_nonzero: assert property (
        state_reg.request && !$past(freeRun) |-> $past(state_reg.count) != 32'h0)
        else $error("count mode request with zero count");
    a_threshold_amount: assert property (
        state_reg.request && $past(thrEnable && freeRun) |-> state_reg.guarantee == $past(thrBytes))
        else $error("threshold guarantee wrong");
    a_wide_even: assert property (
        state_reg.request && $past(bus16 && freeRun && !thrEnable)
        |-> !state_reg.guarantee[0] && state_reg.guarantee >= 16'h2)
        else $error("wide bus guarantee not even");
    a_narrow_all: assert property (
        state_reg.request && $past(!bus16 && freeRun && !thrEnable)
        |-> state_reg.guarantee == $past(readyBytes))
        else $error("narrow bus guarantee not all ready bytes");
    a_start_runs: assert property (
        startPulse && !state_reg.running && !stopPulse |=> state_reg.running)
        else $error("start did not set running");
    a_stop_flags: assert property (
        $fell(state_reg.running) |-> state_reg.complete)
        else $error("stop without completion flag");
    a_final_low: assert property (
        finalAccess ##1 !dmaAccess |-> !reqLive ##1 !reqLive)
        else $error("request after final access");
    a_count_step: assert property (
        accessEnd && state_reg.running && !freeRun && !countExpired
        |=> state_reg.count == $past(state_reg.count) - {30'h0, $past(state_reg.lastBytes)})
        else $error("count not reduced by bytes moved");
    a_write_pulse: assert property (
        (|writeLanes) ##1 !(|writeLanes) |=> regWriteEnable != 2'h0)
        else $error("no write pulse after strobe release");
    a_read_fresh: assert property (
        busDataOe |-> busDataOut == $past(ramWindowSelect ? ramReadData : regReadData))
        else $error("read bus shows stale data");

    c_inbound_req: cover property (state_reg.request && dirIn);
    c_count_expiry: cover property (countExpired);
    c_sw_stop: cover property (state_reg.running && stopPulse);
    c_reg_write: cover property (regWriteEnable == 2'h3);
endmodule // fdr_dma_request

/* File: testbench/fdr_dma_master.sv */
`timescale 1ns/1ps
module fdr_dma_master (
    // clock and control
    input wire logic clk,
    input wire logic en,
    input wire logic dirIn,
    input wire logic slow,
    input wire logic reqActiveHigh,
    input wire logic ackActiveHigh,
    // dma pins
    input wire logic dmaRequestOut,
    output logic ackPin,
    output logic rdN,
    output logic [1:0] wrN
);
    logic act = 1'b0;

    // one access per look at the request, so never more than is guaranteed
    initial begin
        forever begin
            @(posedge clk);
            if (en && dmaRequestOut === reqActiveHigh) begin
                act <= 1'b1;
                repeat (slow ? 8 : 4) @(posedge clk);
                act <= 1'b0;
                // idle long enough for the count update to reach the request
                repeat (slow ? 10 : 7) @(posedge clk);
            end
        end
    end

    assign ackPin = ~(act ^ ackActiveHigh);
    assign rdN = ~(act & ~dirIn);
    assign wrN = {2{~(act & dirIn)}};
endmodule // fdr_dma_master

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin nFail++; $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module tb;
    logic clk, rstN = 1'h0, startP = 1'h0, stopP = 1'h0, clr = 1'h0, rdbl = 1'h0;
    logic reqHi = 1'h0, ackHi = 1'h0;
    logic cpuCsN = 1'h1, cpuRdN = 1'h1, ramSel = 1'h0, mEn = 1'h0, slow = 1'h0;
    logic [5:0] cfg = '0;
    logic [1:0] cpuWrN = 2'b11;
    logic [fdr_pkg::COUNT_W-1:0] cntIn = '0;
    logic [fdr_pkg::READY_W-1:0] rdy = '0;
    logic [fdr_pkg::DATA_W-1:0] dIn = '0;
    logic running, cmpl, done, req, ackPin, mRdN, oe;
    logic [1:0] mWrN, wrEn, mvd;
    logic [fdr_pkg::COUNT_W-1:0] cnt;
    logic [fdr_pkg::READY_W-1:0] gBytes;
    logic [fdr_pkg::DATA_W-1:0] dOut, wData;
    int nFail = 0;
    int checked = 0;
    int cyc = 0;
    int nDone = 0;
    int nBytes = 0;

    // cfg = {dirIn, freeRun, thrEnable, burstThreshold, bus16}; the unused ready is a decoy
    fdr_dma_request u_dut (
        .sys_clk(clk), .reset_n(rstN), .dirIn(cfg[5]), .freeRun(cfg[4]), .thrEnable(cfg[3]),
        .burstThreshold(cfg[2:1]), .bus16(cfg[0]), .reqActiveHigh(reqHi), .ackActiveHigh(ackHi),
        .startPulse(startP), .stopPulse(stopP), .transferCountIn(cntIn), .completeClear(clr),
        .running(running), .completeFlag(cmpl), .transferCount(cnt), .guaranteedBytes(gBytes),
        .transferDone(done), .bytesMoved(mvd), .fifoFree(cfg[5] ? rdy : 16'h00ff),
        .fifoData(cfg[5] ? 16'h00ff : rdy), .fifoReadable(rdbl), .dmaRequestOut(req),
        .dmaAcknowledgeIn(ackPin), .chipSelectN(cpuCsN), .readStrobeN(cpuRdN & mRdN),
        .byteWriteStrobesN(cpuWrN & mWrN), .busDataIn(dIn), .busDataOut(dOut), .busDataOe(oe),
        .ramWindowSelect(ramSel), .regReadData(16'h1234), .ramReadData(16'hbeef),
        .regWriteEnable(wrEn), .regWriteData(wData)
    );

    fdr_dma_master u_master (
        .clk(clk), .en(mEn), .dirIn(cfg[5]), .slow(slow), .reqActiveHigh(reqHi),
        .ackActiveHigh(ackHi), .dmaRequestOut(req), .ackPin(ackPin), .rdN(mRdN), .wrN(mWrN)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (done === 1'b1) begin
            nDone++;
            nBytes += int'(mvd);
        end
        if (cyc == 5000) begin
            nFail++;
            test_done();
        end
    end

    task automatic test_done();
        if (nFail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // stop any run, then start a fresh one with the given setup
    task automatic go(input logic [5:0] c, input logic [15:0] r, input logic ok,
                      input logic [31:0] n);
        @(posedge clk);
        stopP <= 1'b1;
        @(posedge clk);
        stopP <= 1'b0;
        startP <= 1'b1;
        clr <= 1'b1;
        cfg <= c;
        rdy <= r;
        rdbl <= ok;
        cntIn <= n;
        @(posedge clk);
        startP <= 1'b0;
        clr <= 1'b0;
    endtask

    task automatic rq(input logic [5:0] c, input logic [15:0] r, input logic ok,
                      input logic [31:0] n, input logic er, input logic [15:0] eg);
        go(c, r, ok, n);
        repeat (3) @(posedge clk);
        #1;
        `CHK(req, ~(er ^ reqHi))
        `CHK(gBytes, eg)
    endtask

    task automatic xfer(input logic [5:0] c, input logic [31:0] n, input int k);
        go(c, 16'h0040, 1'b1, n);
        mEn <= 1'b1;
        nDone = 0;
        nBytes = 0;
        #1;
        `CHK(running, 1'b1)
        `CHK(cmpl, 1'b0)
        for (int i = 0; i < 600 && running === 1'b1; i++)
            @(posedge clk);
        #1;
        `CHK(cmpl, 1'b1)
        `CHK(cnt, 32'h0)
        `CHK(nDone, k)
        `CHK(nBytes, int'(n))
        `CHK(req, ~reqHi)
        @(posedge clk);
        mEn <= 1'b0;
    endtask

    task automatic wr(input logic [1:0] ln, input logic [15:0] d);
        @(posedge clk);
        cpuCsN <= 1'b0;
        cpuWrN <= ~ln;
        dIn <= d;
        repeat (4) @(posedge clk);
        cpuCsN <= 1'b1;
        cpuWrN <= 2'b11;
        // new bus data at release must not leak into the write
        dIn <= ~d;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1;
            if (wrEn !== 2'b00)
                break;
        end
        `CHK(wrEn, ln)
        `CHK(wData & {{8{ln[1]}}, {8{ln[0]}}}, d & {{8{ln[1]}}, {8{ln[0]}}})
    endtask

    task automatic rdt(input logic cs, input logic rs, input logic [15:0] e);
        @(posedge clk);
        cpuCsN <= cs;
        cpuRdN <= 1'b0;
        ramSel <= rs;
        repeat (4) @(posedge clk);
        #1;
        `CHK(oe, ~cs)
        if (!cs)
            `CHK(dOut, e)
        @(posedge clk);
        cpuCsN <= 1'b1;
        cpuRdN <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(oe, 1'b0)
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #1;
        `CHK(req, 1'b1)
        `CHK(running, 1'b0)
        @(posedge clk);
        rstN <= 1'b1;
        repeat (5) @(posedge clk);
        rq(6'b100001, 16'h5, 1'b1, 32'h64, 1'b1, 16'h4);
        rq(6'b100001, 16'h1, 1'b1, 32'h64, 1'b0, 16'h0);
        rq(6'b100001, 16'h1, 1'b1, 32'h1, 1'b1, 16'h1);
        rq(6'b100000, 16'h1, 1'b1, 32'h64, 1'b1, 16'h1);
        rq(6'b100000, 16'h7, 1'b1, 32'h3, 1'b1, 16'h3);
        rq(6'b000001, 16'h6, 1'b0, 32'h64, 1'b0, 16'h0);
        rq(6'b000001, 16'h6, 1'b1, 32'h64, 1'b1, 16'h6);
        rq(6'b110001, 16'h3, 1'b1, 32'h0, 1'b1, 16'h2);
        rq(6'b110000, 16'h3, 1'b1, 32'h0, 1'b1, 16'h3);
        rq(6'b100001, 16'h9, 1'b1, 32'h0, 1'b0, 16'h0);
        for (int i = 0; i < 4; i++) begin
            rq({3'b111, 2'(i), 1'b1}, 16'h2 << i, 1'b1, 32'h0, 1'b1, 16'h2 << i);
            rq({3'b111, 2'(i), 1'b1}, (16'h2 << i) - 16'h1, 1'b1, 32'h0, 1'b0, 16'h0);
        end
        rq(6'b101011, 16'h3, 1'b1, 32'h64, 1'b0, 16'h0);
        rq(6'b101011, 16'h3, 1'b1, 32'h3, 1'b1, 16'h3);
        rq(6'b101011, 16'h2, 1'b1, 32'h3, 1'b0, 16'h0);
        @(posedge clk);
        reqHi <= 1'b1;
        rq(6'b100001, 16'h5, 1'b1, 32'h64, 1'b1, 16'h4);
        // software stop of the live run
        @(posedge clk);
        stopP <= 1'b1;
        @(posedge clk);
        stopP <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(cmpl, 1'b1)
        `CHK(running, 1'b0)
        `CHK(req, 1'b0)
        xfer(6'b100001, 32'h5, 3);
        ackHi <= 1'b1;
        slow <= 1'b1;
        xfer(6'b000000, 32'h3, 3);
        wr(2'b01, 16'h5a3c);
        wr(2'b10, 16'hc3a5);
        wr(2'b11, 16'h9617);
        rdt(1'b0, 1'b0, 16'h1234);
        rdt(1'b0, 1'b1, 16'hbeef);
        rdt(1'b1, 1'b0, 16'h1234);
        test_done();
    end
endmodule // tb
